// [oscillator_control_ready_logic.sv]
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module oscillator_control_ready_logic
	import osc_ctrl_pkg::*;
#(
	parameter int startup_unit = tick_cycles
) (
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire logic                 por_reset,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	input  wire osc_ctrl_pkg::sleep_t sleep_mode,
	input  wire logic                 ext_osc_request,
	input  wire logic                 int32k_request,
	input  wire logic [2:0]           ready_raw,
	output osc_ctrl_pkg::pin_ctrl_t   main_pins,
	output osc_ctrl_pkg::pin_ctrl_t   slow_pins,
	output logic                      ext_osc_run,
	output logic                      ext_osc_clk_gate,
	output logic                      ext_osc_auto_amp,
	output logic [3:0]                ext_osc_gain,
	output logic                      ext32k_run,
	output logic                      ext32k_gate_32k,
	output logic                      ext32k_gate_1k,
	output logic                      int32k_run,
	output logic                      int32k_gate_32k,
	output logic                      int32k_gate_1k,
	output logic [6:0]                int32k_trim,
	output logic                      irq
);
	import osc_ctrl_pkg::*;

	// State of the block apart from the slow control word
	typedef struct packed {
		logic [31:0]  main_ctrl;      // Main oscillator control word
		logic [31:0]  int_ctrl;       // Internal oscillator control word
		logic [6:0]   trim_pending;   // Trim written, waiting to commit
		logic         trim_wait;      // Pending trim not yet applied
		logic [2:0]   irq_en;         // Interrupt enables
		logic [2:0]   irq_flag;       // Sticky ready-edge flags
		logic [2:0]   sync1;          // First synchroniser stage
		logic [2:0]   sync2;          // Second synchroniser stage
		logic [2:0]   ready_q;        // Previous ready, edge detection
		osc_state_t   main_st;        // Main oscillator sequencing
		logic [23:0]  main_cnt;       // Main start-up counter, wide enough for the longest setting
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
		pin_ctrl_t    main_pins;
		pin_ctrl_t    slow_pins;
		logic         ext_osc_run;
		logic         ext_osc_clk_gate;
		logic         ext_osc_auto_amp;
		logic [3:0]   ext_osc_gain;
		logic         ext32k_run;
		logic         ext32k_gate_32k;
		logic         ext32k_gate_1k;
		logic         int32k_run;
		logic         int32k_gate_32k;
		logic         int32k_gate_1k;
		logic [6:0]   int32k_trim;
		logic         irq;
	} state_t;

	state_t state;       // Registered state
	state_t next_state;  // Next state
	logic [31:0] slow_ctrl;       // Slow external control, power-on domain
	logic [31:0] next_slow_ctrl;  // Next slow external control word

	// Access phase of an APB transfer
	logic        access;
	logic        wr;
	logic        slow_wr;
	logic [23:0] startup_len;
	logic        main_want;
	logic [2:0]  ready_now;   // Ready bits as software sees them

	// Decoded fields of the main, slow and internal control words
	logic main_en, main_xtal, slow_en, slow_xtal, int_en;
	assign main_en   = state.main_ctrl[enable_pos];
	assign main_xtal = state.main_ctrl[crystal_sel_pos];
	assign slow_en   = slow_ctrl[enable_pos];
	assign slow_xtal = slow_ctrl[crystal_sel_pos];
	assign int_en    = state.int_ctrl[enable_pos];
	assign access    = psel && penable;
	assign wr        = access && pwrite;
	// Only the first access cycle, while pready is still low, writes, so a held request lands once
	assign slow_wr   = wr && !state.pready && (paddr == ext32k_ctrl_offset);

	// Start-up length: 2^startup units of the base tick
	assign startup_len = 24'(startup_unit) << state.main_ctrl[startup_pos +: 4];

	// Main ready only once its own start-up time is over
	// A raw ready alone could announce a clock that is still masked
	assign ready_now = {state.sync2[int32k_bit], state.sync2[ext32k_bit],
		state.sync2[ext_osc_bit] && (state.main_st == osc_ready)};

	// Sleep policy decides whether the main oscillator runs
	// Request gates idle running when run_on_request set
	always_comb begin
		main_want = 1'b0;
		if (!main_en) begin
			main_want = 1'b0;
		end else if (sleep_mode.standby) begin
			if (!state.main_ctrl[run_stdby_pos]) begin
				main_want = 1'b0;
			end else begin
				main_want = !state.main_ctrl[run_req_pos] || ext_osc_request;
			end
		end else if (sleep_mode.idle) begin
			main_want = !state.main_ctrl[run_req_pos] || ext_osc_request;
		end else begin
			main_want = 1'b1;
		end
	end

	// Slow external control word, cleared only by power-on reset
	always_comb begin
		next_slow_ctrl = slow_ctrl;
		if (slow_wr) begin
			next_slow_ctrl = pwdata;
		end
	end

	// Slow oscillator off at power-on only
	// Ordinary reset leaves slow oscillator running
	always_ff @(posedge sys_clk) begin
		if (por_reset) begin
			slow_ctrl <= ext32k_ctrl_reset;
		end else begin
			slow_ctrl <= next_slow_ctrl;
		end
	end

	// Next state of the block apart from the slow control word
	always_comb begin
		next_state = state;
		next_state.pready  = 1'b0;
		next_state.pslverr = 1'b0;

		next_state.sync1   = ready_raw;
		next_state.sync2   = state.sync1;
		next_state.ready_q = ready_now;

		// Bus slave: one wait state, answer on second access cycle
		if (access && !state.pready) begin
			next_state.pready = 1'b1;
			next_state.prdata = 32'h0000_0000;
			unique case (paddr)
				ext_osc_ctrl_offset: begin
					next_state.prdata = state.main_ctrl;
					if (pwrite) begin
						next_state.main_ctrl = pwdata;
					end
				end
				ext32k_ctrl_offset: begin
					next_state.prdata = slow_ctrl;
				end
				int32k_ctrl_offset: begin
					next_state.prdata = state.int_ctrl;
					if (pwrite) begin
						next_state.int_ctrl     = pwdata;
						next_state.trim_pending = pwdata[trim_pos +: 7];
						next_state.trim_wait    = 1'b1;
					end
				end
				status_offset: begin
					next_state.prdata = {29'h0000_0000, ready_now};
				end
				irq_enable_offset: begin
					next_state.prdata = {29'h0000_0000, state.irq_en};
					if (pwrite) begin
						next_state.irq_en = pwdata[2:0];
					end
				end
				irq_flag_offset: begin
					next_state.prdata = {29'h0000_0000, state.irq_flag};
					if (pwrite) begin
						next_state.irq_flag = state.irq_flag & ~pwdata[2:0];
					end
				end
				default: begin
					next_state.pslverr = 1'b1;
				end
			endcase
		end

		// Rising edge of ready sets flag, set beats clear
		// Same edge capture for the slow oscillator
		next_state.irq_flag = next_state.irq_flag | (ready_now & ~state.ready_q);
		// Mask taken from the new enables so irq never outlives a cleared enable
		next_state.irq = |(next_state.irq_flag & next_state.irq_en);

		// Trim reaches oscillator only once ready is high
		if (state.trim_wait && state.sync2[int32k_bit] && int_en) begin
			next_state.int32k_trim = state.trim_pending;
			next_state.trim_wait   = 1'b0;
		end

		// Main start-up sequencing masks the output
		// Ready follows the elapsed start-up time
		unique case (state.main_st)
			osc_off: begin
				next_state.main_cnt = 24'h00_0000;
				if (main_want) begin
					next_state.main_st = osc_starting;
				end
			end
			osc_starting: begin
				if (!main_want) begin
					next_state.main_st = osc_off;
				end else if (state.main_cnt >= startup_len) begin
					next_state.main_st = osc_ready;
				end else begin
					next_state.main_cnt = state.main_cnt + 24'h00_0001;
				end
			end
			osc_ready: begin
				if (!main_want) begin
					next_state.main_st = osc_off;
				end
			end
		endcase

		next_state.ext_osc_run      = main_want;
		next_state.ext_osc_clk_gate = (state.main_st == osc_ready) && main_want;
		// Gain passed straight from software setting
		next_state.ext_osc_gain     = state.main_ctrl[gain_pos +: 4];
		// Amplitude loop only in crystal mode
		next_state.ext_osc_auto_amp = main_en && main_xtal && state.main_ctrl[auto_amp_pos];

		// External clock takes input pin only
		next_state.main_pins.in_override  = main_en;
		next_state.main_pins.out_override = main_en && main_xtal;

		// Slow oscillator pin override by mode
		next_state.slow_pins.in_override  = slow_en;
		next_state.slow_pins.out_override = slow_en && slow_xtal;

		// Slow oscillator runs regardless of sleep mode
		next_state.ext32k_run = slow_en;
		// Slow outputs held off until ready
		// Slow outputs only in crystal mode
		next_state.ext32k_gate_32k = slow_en && slow_xtal && state.sync2[ext32k_bit]
			&& slow_ctrl[out_32k_pos];
		next_state.ext32k_gate_1k  = slow_en && slow_xtal && state.sync2[ext32k_bit]
			&& slow_ctrl[out_1k_pos];

		// Internal oscillator follows its enable bit; request gates it in idle only, and standby stops it unless run_in_standby is set
		next_state.int32k_run = int_en && (!sleep_mode.idle || !state.int_ctrl[run_req_pos]
			|| int32k_request) && (!sleep_mode.standby || state.int_ctrl[run_stdby_pos]);
		// Internal outputs gated by their enable bits
		next_state.int32k_gate_32k = int_en && state.sync2[int32k_bit] && state.int_ctrl[out_32k_pos];
		next_state.int32k_gate_1k  = int_en && state.sync2[int32k_bit] && state.int_ctrl[out_1k_pos];
	end

	// Register the state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state           <= '0;
			state.main_ctrl <= ext_osc_ctrl_reset;
			state.int_ctrl  <= int32k_ctrl_reset;
			state.main_st   <= osc_off;
			// Slow oscillator side rides through an ordinary reset
			state.slow_pins       <= next_state.slow_pins;
			state.ext32k_run      <= next_state.ext32k_run;
			state.ext32k_gate_32k <= next_state.ext32k_gate_32k;
			state.ext32k_gate_1k  <= next_state.ext32k_gate_1k;
			// Synchronisers keep tracking so no false ready edge follows reset
			state.sync1           <= next_state.sync1;
			state.sync2           <= next_state.sync2;
			state.ready_q         <= next_state.ready_q;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from flip-flops
	assign pready           = state.pready;
	assign pslverr          = state.pslverr;
	assign prdata           = state.prdata;
	assign main_pins        = state.main_pins;
	assign slow_pins        = state.slow_pins;
	assign ext_osc_run      = state.ext_osc_run;
	assign ext_osc_clk_gate = state.ext_osc_clk_gate;
	assign ext_osc_auto_amp = state.ext_osc_auto_amp;
	assign ext_osc_gain     = state.ext_osc_gain;
	assign ext32k_run       = state.ext32k_run;
	assign ext32k_gate_32k  = state.ext32k_gate_32k;
	assign ext32k_gate_1k   = state.ext32k_gate_1k;
	assign int32k_run       = state.int32k_run;
	assign int32k_gate_32k  = state.int32k_gate_32k;
	assign int32k_gate_1k   = state.int32k_gate_1k;
	assign int32k_trim      = state.int32k_trim;
	assign irq              = state.irq;

	// Disabled main oscillator leaves both pins free
	main_pins_free_a: assert property (@(posedge sys_clk) disable iff (reset)
		!main_en |=> !main_pins.in_override && !main_pins.out_override)
		else $error("main pins overridden while disabled");

	// Crystal mode drives both pins
	main_xtal_pins_a: assert property (@(posedge sys_clk) disable iff (reset)
		main_en && main_xtal |=> main_pins.out_override && main_pins.in_override)
		else $error("crystal mode missing pin override");

	// External clock mode leaves output pin free
	main_ext_pin_a: assert property (@(posedge sys_clk) disable iff (reset)
		main_en && !main_xtal |=> main_pins.in_override && !main_pins.out_override)
		else $error("external clock mode overrode output pin");

	// Standby without run_in_standby stops the oscillator
	standby_stop_a: assert property (@(posedge sys_clk) disable iff (reset)
		sleep_mode.standby && !state.main_ctrl[run_stdby_pos] |=> !ext_osc_run)
		else $error("main oscillator ran in standby");

	// Output never ungated while still starting
	startup_mask_a: assert property (@(posedge sys_clk) disable iff (reset)
		state.main_st != osc_ready |=> !ext_osc_clk_gate)
		else $error("main clock ungated during start-up");

	// Ready edge raises its flag
	ready_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(ready_now[ext_osc_bit]) |=> state.irq_flag[ext_osc_bit])
		else $error("ready edge lost");

	// Slow outputs absent in external clock mode
	slow_ext_out_a: assert property (@(posedge sys_clk) disable iff (reset)
		!slow_xtal |=> !ext32k_gate_32k && !ext32k_gate_1k)
		else $error("slow output in external clock mode");

	// Interrupt follows flag and mask
	irq_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
		!(|(state.irq_flag & state.irq_en)) |-> !irq)
		else $error("interrupt without enabled flag");

	// Slow oscillator keeps running across an ordinary reset
	slow_keep_a: assert property (@(posedge sys_clk) disable iff (por_reset)
		slow_en && !slow_wr |=> slow_en)
		else $error("slow oscillator lost enable");

endmodule
`default_nettype wire

// [osc_ctrl_pkg.sv]
package osc_ctrl_pkg;

	// Register byte offsets
	localparam logic [11:0] ext_osc_ctrl_offset   = 12'h000;
	localparam logic [11:0] ext32k_ctrl_offset    = 12'h004;
	localparam logic [11:0] int32k_ctrl_offset    = 12'h008;
	localparam logic [11:0] status_offset         = 12'h00c;
	localparam logic [11:0] irq_enable_offset     = 12'h010;
	localparam logic [11:0] irq_flag_offset       = 12'h014;

	// Field positions in the oscillator control words
	localparam int enable_pos        = 1;
	localparam int crystal_sel_pos   = 2;
	localparam int out_32k_pos       = 3;
	localparam int out_1k_pos        = 4;
	localparam int auto_amp_pos      = 5;
	localparam int run_stdby_pos     = 6;
	localparam int run_req_pos       = 7;
	localparam int startup_pos       = 8;
	localparam int gain_pos          = 12;
	localparam int trim_pos          = 16;

	// Status and interrupt bit positions
	localparam int ext_osc_bit       = 0;
	localparam int ext32k_bit        = 1;
	localparam int int32k_bit        = 2;

	// Values after reset
	localparam logic [31:0] ext_osc_ctrl_reset = 32'h0000_0080;
	localparam logic [31:0] ext32k_ctrl_reset  = 32'h0000_0080;
	localparam logic [31:0] int32k_ctrl_reset  = 32'h0000_0080;

	// Start-up base tick: 1 us at 100 MHz
	localparam int sys_clk_mhz       = 100;
	localparam int tick_time_us      = 1;
	localparam int tick_cycles       = tick_time_us * sys_clk_mhz;

	// Oscillator start-up sequencing
	typedef enum logic [2:0] {
		osc_off      = 3'b001,
		osc_starting = 3'b010,
		osc_ready    = 3'b100
	} osc_state_t;

	// Per oscillator decoded settings
	typedef struct packed {
		logic       enable;
		logic       crystal;
		logic       out_32k;
		logic       out_1k;
		logic       auto_amp;
		logic       run_stdby;
		logic       run_req;
		logic [3:0] startup;
		logic [3:0] gain;
		logic [6:0] trim;
	} osc_cfg_t;

	// Pin override group for one oscillator
	typedef struct packed {
		logic in_override;
		logic out_override;
	} pin_ctrl_t;

	// Sleep mode seen from the power manager
	typedef struct packed {
		logic idle;
		logic standby;
	} sleep_t;

endpackage

// [osc_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module osc_partner #(
	parameter int settle = 5
) (
	input  wire logic [2:0] run,
	input  wire logic       sys_clk,
	output logic [2:0]      ready_raw
);
	// Cycles each oscillator has been running since it was last started
	int unsigned age [3];

	// Nothing oscillates before the first start
	initial begin
		ready_raw = 3'h0;
	end

	// Ready follows run after a settling delay and drops at once on stop;
	// moved on the falling edge so it is never aligned with the bus clock
	always @(negedge sys_clk) begin
		for (int i = 0; i < 3; i++) begin
			age[i] = run[i] ? age[i] + 1 : 0;
			ready_raw[i] <= (age[i] >= settle);
		end
	end
endmodule
`default_nettype wire

// [oscillator_control_ready_logic_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module oscillator_control_ready_logic_tb;
	import osc_ctrl_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        por_reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        pready, pslverr, er, irq;
	logic [31:0] prdata, rd;
	sleep_t      sleep_mode = '0;
	logic        ext_osc_request = 1'b0;
	logic        int32k_request = 1'b0;
	logic [2:0]  ready_raw;
	pin_ctrl_t   main_pins, slow_pins;
	logic        ext_osc_run, ext_osc_clk_gate, ext_osc_auto_amp;
	logic [3:0]  ext_osc_gain;
	logic        ext32k_run, ext32k_gate_32k, ext32k_gate_1k;
	logic        int32k_run, int32k_gate_32k, int32k_gate_1k;
	logic [6:0]  int32k_trim;
	logic        x;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;

	// Start-up counts shortened to one cycle per unit
	oscillator_control_ready_logic #(.startup_unit(1)) dut_u (.sys_clk(sys_clk), .reset(reset),
		.por_reset(por_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.sleep_mode(sleep_mode), .ext_osc_request(ext_osc_request),
		.int32k_request(int32k_request), .ready_raw(ready_raw), .main_pins(main_pins),
		.slow_pins(slow_pins), .ext_osc_run(ext_osc_run), .ext_osc_clk_gate(ext_osc_clk_gate),
		.ext_osc_auto_amp(ext_osc_auto_amp), .ext_osc_gain(ext_osc_gain),
		.ext32k_run(ext32k_run), .ext32k_gate_32k(ext32k_gate_32k),
		.ext32k_gate_1k(ext32k_gate_1k), .int32k_run(int32k_run),
		.int32k_gate_32k(int32k_gate_32k), .int32k_gate_1k(int32k_gate_1k),
		.int32k_trim(int32k_trim), .irq(irq));

	// Oscillators at the far side
	osc_partner #(.settle(5)) osc_u (.sys_clk(sys_clk),
		.run({int32k_run, ext32k_run, ext_osc_run}), .ready_raw(ready_raw));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// Compare one value and report a difference
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Let registered outputs settle after a write or input change
	task automatic settle();
		repeat (4) @(posedge sys_clk);
	endtask

	// Read status until one ready bit is up; the bench timeout ends a hang
	task automatic poll(input int b);
		do begin
			apb(1'b0, status_offset, 32'h0);
		end while (rd[b] !== 1'b1);
	endtask

	// Verdict and end of run
	task automatic tally_and_finish();
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cut a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		por_reset <= 1'b0;
		@(posedge sys_clk);
		check("pins", {main_pins, slow_pins}, 32'h0);
		check("runs", {ext_osc_run, ext32k_run, int32k_run}, 32'h0);
		apb(1'b0, ext_osc_ctrl_offset, 32'h0);
		check("main ctrl", rd, ext_osc_ctrl_reset);
		apb(1'b0, ext32k_ctrl_offset, 32'h0);
		check("slow ctrl", rd, ext32k_ctrl_reset);
		apb(1'b0, 12'h0f0, 32'h0);
		check("unmapped err", er, 1'b1);
		apb(1'b1, irq_enable_offset, 32'h1);
		// Crystal, auto amplitude, gain 5, start-up field 4, runs without request, off in standby
		apb(1'b1, ext_osc_ctrl_offset, 32'h5426);
		@(posedge sys_clk);
		check("main masked", ext_osc_clk_gate, 1'b0);
		check("main pins xtal", main_pins, 2'b11);
		check("main run", ext_osc_run, 1'b1);
		check("auto amp", ext_osc_auto_amp, 1'b1);
		check("gain", ext_osc_gain, 4'h5);
		poll(ext_osc_bit);
		check("main ready", rd[ext_osc_bit], 1'b1);
		settle();
		check("main gate", ext_osc_clk_gate, 1'b1);
		check("irq raised", irq, 1'b1);
		apb(1'b0, irq_flag_offset, 32'h0);
		check("irq flag", rd[2:0], 3'h1);
		apb(1'b1, irq_flag_offset, 32'h1);
		settle();
		check("irq cleared", irq, 1'b0);
		apb(1'b1, ext_osc_ctrl_offset, 32'h0402);
		settle();
		check("main pins ext", main_pins, 2'b10);
		// Slow crystal with both outputs; its interrupt stays masked
		apb(1'b1, ext32k_ctrl_offset, 32'h1e);
		settle();
		check("slow pins xtal", slow_pins, 2'b11);
		check("slow masked", ext32k_gate_32k, 1'b0);
		poll(ext32k_bit);
		settle();
		check("slow outputs", {ext32k_gate_32k, ext32k_gate_1k}, 2'b11);
		check("irq masked", irq, 1'b0);
		apb(1'b0, irq_flag_offset, 32'h0);
		check("slow flag", rd[ext32k_bit], 1'b1);
		// Disable by enable bit alone, change mode, enable again
		apb(1'b1, ext32k_ctrl_offset, 32'h1c);
		settle();
		check("slow stop", ext32k_run, 1'b0);
		apb(1'b1, ext32k_ctrl_offset, 32'h18);
		apb(1'b1, ext32k_ctrl_offset, 32'h1a);
		poll(ext32k_bit);
		settle();
		check("slow pins ext", slow_pins, 2'b10);
		check("slow outs ext", {ext32k_gate_32k, ext32k_gate_1k}, 2'b00);
		// Trim written while stopped is not yet committed
		apb(1'b1, int32k_ctrl_offset, 32'h550018);
		settle();
		check("trim held", int32k_trim, 7'h00);
		apb(1'b1, int32k_ctrl_offset, 32'h55001a);
		poll(int32k_bit);
		settle();
		check("int run", int32k_run, 1'b1);
		check("int outs", {int32k_gate_32k, int32k_gate_1k}, 2'b11);
		check("trim", int32k_trim, 7'h55);
		apb(1'b1, int32k_ctrl_offset, 32'h550018);
		settle();
		check("int stop", int32k_run, 1'b0);
		// Sleep policy table: standby bit, request bit, mode, request line
		for (int i = 0; i < 16; i++) begin
			sleep_mode <= '0;
			apb(1'b1, ext_osc_ctrl_offset, 32'h0402 | (i[0] << 6) | (i[1] << 7));
			// Sleep only once the main oscillator has finished starting
			poll(ext_osc_bit);
			sleep_mode <= {~i[2], i[2]};
			ext_osc_request <= i[3];
			settle();
			x = (!i[1] || i[3]) && (!i[2] || i[0]);
			check("sleep run", ext_osc_run, x);
			check("slow sleep", ext32k_run, 1'b1);
		end
		sleep_mode <= '0;
		ext_osc_request <= 1'b0;
		// Plain reset keeps the slow oscillator and its word
		reset <= 1'b1;
		repeat (16) @(posedge sys_clk);
		check("slow in reset", ext32k_run, 1'b1);
		check("slow pins in reset", slow_pins, 2'b10);
		reset <= 1'b0;
		settle();
		check("slow kept", ext32k_run, 1'b1);
		check("main off", main_pins, 2'b00);
		apb(1'b0, ext32k_ctrl_offset, 32'h0);
		check("slow word", rd, 32'h1a);
		apb(1'b0, ext_osc_ctrl_offset, 32'h0);
		check("main word", rd, ext_osc_ctrl_reset);
		tally_and_finish();
	end
endmodule
`default_nettype wire
